// ---- design/twsm_master.sv ----
`timescale 1ns/100ps
`default_nettype none
module twsm_master (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic [7:0] prescaler_i,
  input wire logic filter_en_i,
  input wire logic irq_en_i,
  input wire logic load_target_address_i,
  input wire logic [6:0] target_addr_i,
  input wire logic target_rd_i,
  input wire logic load_tx_byte_i,
  input wire logic [7:0] tx_byte_i,
  output logic buf_ready_o,
  input wire logic issue_bus_command_i,
  input wire logic cmd_start_i,
  input wire logic cmd_stop_i,
  input wire logic cmd_write_i,
  input wire logic cmd_read_i,
  input wire logic cmd_nack_i,
  output logic cmd_ready_o,
  output logic busy_o,
  output logic rx_nack_o,
  output logic arb_lost_o,
  output logic [7:0] rx_data_o,
  output logic done_o,
  output logic serial_iface_irq_source_o,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe_o
);
  typedef struct packed {
    twsm_pkg::twsm_state_t state;
    logic [2:0] phase;
    logic [7:0] pcnt;
    logic [7:0] acc;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic [7:0] rx;
    logic c_start;
    logic c_stop;
    logic c_wr;
    logic c_rd;
    logic c_nack;
    logic owned;
    logic scl_oe;
    logic sda_oe;
    logic busy;
    logic nack;
    logic arb;
    logic done;
    logic irq;
    logic en_d;
    logic [7:0] cfg_presc;
    logic cfg_filt;
    logic cfg_irq;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] lvl;
    logic [1:0][3:0] fcnt;
  } twsm_regs_t;
  twsm_regs_t r, n;
  logic cmd_go, tick, stretch, adv, enter, do0, fifo_rd_ready, fifo_rd_valid;
  logic [2:0] np;
  logic [7:0] acc_sum, fifo_rd_data, fifo_wr_data;

  ////////////////////////////////////////////////////////////////////////////
  // transmit buffer: loads only store, the bus sees nothing yet
  assign fifo_wr_data = load_target_address_i ? {target_addr_i, target_rd_i} : tx_byte_i; // [R7]
  assign fifo_rd_ready = r.state == twsm_pkg::S_FETCH;

  twsm_fifo #(
    .W(twsm_pkg::BYTE_W),
    .D(twsm_pkg::FIFO_DEPTH)
  ) u_txbuf (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .wr_valid_i(load_target_address_i || load_tx_byte_i),
    .wr_ready_o(buf_ready_o),
    .wr_data_i(fifo_wr_data),
    .rd_valid_o(fifo_rd_valid),
    .rd_ready_i(fifo_rd_ready),
    .rd_data_o(fifo_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign cmd_ready_o = enable_i && !r.busy;
  assign cmd_go = issue_bus_command_i && cmd_ready_o && (cmd_start_i || cmd_stop_i || cmd_write_i || cmd_read_i);
  assign acc_sum = r.acc + twsm_pkg::REF_STEP;
  assign tick = acc_sum >= twsm_pkg::REF_MOD;
  // clock stretching: a released clock line still held low freezes the phase
  assign stretch = r.phase >= twsm_pkg::PH_RISE && !r.scl_oe && !r.lvl[0];
  assign np = (r.phase == twsm_pkg::PH_LAST) ? 3'h0 : r.phase + 3'h1;

  always_comb
  begin
    n = r;
    n.done = 1'b0;
    n.irq = 1'b0;
    adv = 1'b0;
    enter = 1'b0;
    do0 = 1'b0;
    n.en_d = enable_i;
    n.acc = tick ? acc_sum - twsm_pkg::REF_MOD : acc_sum;
    n.s1 = {serial_data_pin_i, serial_clock_pin_i}; // [R2]
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < 2; i++)
    begin
      if (r.s2[i] != r.s3[i] || r.s3[i] == r.lvl[i])
        n.fcnt[i] = 4'h0;
      else if (!r.cfg_filt || r.fcnt[i] == twsm_pkg::FILT_LAST) // [R3]
      begin
        n.lvl[i] = r.s3[i];
        n.fcnt[i] = 4'h0;
      end
      else
        n.fcnt[i] = r.fcnt[i] + 4'h1;
    end
    // bus phase rate: 16 MHz reference divided by prescaler plus one, five phases a bit
    if (tick && r.busy)
    begin
      if (r.pcnt == r.cfg_presc) // [R1]
      begin
        if (!stretch)
        begin
          adv = 1'b1;
          n.pcnt = 8'h00;
        end
      end
      else
        n.pcnt = r.pcnt + 8'h01;
    end
    if (!enable_i)
    begin
      n.state = twsm_pkg::S_IDLE; // [R4]
      n.busy = 1'b0;
      n.owned = 1'b0;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
      n.phase = 3'h0;
    end
    else
    begin
      if (!r.en_d)
      begin
        n.cfg_presc = prescaler_i; // [R1]
        n.cfg_filt = filter_en_i; // [R3]
        n.cfg_irq = irq_en_i; // [R16]
      end
      case (r.state)
        twsm_pkg::S_IDLE:
          if (cmd_go)
          begin
            n.c_start = cmd_start_i;
            n.c_stop = cmd_stop_i;
            n.c_wr = cmd_write_i;
            n.c_rd = cmd_read_i;
            n.c_nack = cmd_nack_i;
            n.busy = 1'b1; // [R17]
            n.nack = 1'b0;
            n.arb = 1'b0;
            n.pcnt = 8'h00;
            if (cmd_write_i)
              n.state = twsm_pkg::S_FETCH;
            else
            begin
              enter = 1'b1;
              if (cmd_start_i)
                n.state = twsm_pkg::S_START;
              else if (cmd_read_i)
                n.state = twsm_pkg::S_BIT; // [R20]
              else
                n.state = twsm_pkg::S_STOP;
            end
          end
        twsm_pkg::S_FETCH:
          if (fifo_rd_valid)
          begin
            n.sh = fifo_rd_data;
            enter = 1'b1;
            n.state = r.c_start ? twsm_pkg::S_START : twsm_pkg::S_BIT; // [R8] [R12]
          end
        default:
          if (adv)
          begin
            n.phase = np;
            if (r.phase == twsm_pkg::PH_LAST)
            begin
              case (r.state)
                twsm_pkg::S_START:
                  if (r.c_wr || r.c_rd)
                    n.state = twsm_pkg::S_BIT; // [R8]
                  else
                  begin
                    n.state = twsm_pkg::S_IDLE;
                    n.owned = 1'b1;
                    n.scl_oe = 1'b1;
                  end
                twsm_pkg::S_BIT:
                begin
                  n.bitn = r.bitn + 3'h1;
                  if (!r.c_rd)
                    n.sh = {r.sh[6:0], 1'b0};
                  if (r.bitn == twsm_pkg::BIT_LAST)
                  begin
                    n.state = twsm_pkg::S_ACK;
                    if (r.c_rd)
                      n.rx = r.sh; // [R20]
                  end
                end
                twsm_pkg::S_ACK:
                  if (r.c_stop)
                    n.state = twsm_pkg::S_STOP; // [R13]
                  else
                  begin
                    n.state = twsm_pkg::S_IDLE; // [R12]
                    n.owned = 1'b1;
                    n.scl_oe = 1'b1;
                  end
                default:
                begin
                  n.state = twsm_pkg::S_IDLE;
                  n.owned = 1'b0;
                end
              endcase
              if (n.state == twsm_pkg::S_IDLE)
              begin
                n.busy = 1'b0; // [R21]
                n.done = 1'b1;
                n.irq = r.cfg_irq; // [R16]
              end
            end
          end
      endcase
      if (enter)
      begin
        n.phase = 3'h0;
        n.bitn = 3'h0;
      end
      do0 = enter || (adv && np == 3'h0 && n.state != twsm_pkg::S_IDLE);
      // open drain: the enables only ever pull a line low
      if (do0)
      begin
        case (n.state)
          twsm_pkg::S_START: n.sda_oe = 1'b0;
          twsm_pkg::S_BIT:
          begin
            n.scl_oe = 1'b1;
            n.sda_oe = !n.c_rd && !n.sh[7]; // [R22]
          end
          twsm_pkg::S_ACK:
          begin
            n.scl_oe = 1'b1;
            n.sda_oe = n.c_rd && !n.c_nack; // [R20]
          end
          twsm_pkg::S_STOP:
          begin
            n.scl_oe = 1'b1;
            n.sda_oe = 1'b1;
          end
          default: n.sda_oe = r.sda_oe;
        endcase
      end
      else if (adv && np == twsm_pkg::PH_RISE)
        n.scl_oe = 1'b0;
      // clock falls one phase before data moves, so data bits never change under a high clock
      else if (adv && np == twsm_pkg::PH_LAST && r.state != twsm_pkg::S_STOP)
        n.scl_oe = 1'b1;
      else if (adv && np == twsm_pkg::PH_SAMPLE)
      begin
        case (r.state)
          twsm_pkg::S_START: n.sda_oe = 1'b1; // [R8]
          twsm_pkg::S_STOP: n.sda_oe = 1'b0; // [R13]
          twsm_pkg::S_BIT:
            if (r.c_rd)
              n.sh = {r.sh[6:0], r.lvl[1]};
            else if (r.sh[7] && !r.lvl[1])
            begin
              n.state = twsm_pkg::S_IDLE; // [R5] [R6]
              n.busy = 1'b0;
              n.owned = 1'b0;
              n.scl_oe = 1'b0;
              n.sda_oe = 1'b0;
              n.arb = 1'b1; // [R19]
              n.done = 1'b1;
              n.irq = r.cfg_irq;
            end
          twsm_pkg::S_ACK:
            if (!r.c_rd)
              n.nack = r.lvl[1]; // [R18] [R15]
          default: n.nack = r.nack;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      r <= '0;
    else
      r <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign serial_clock_pin_o = 1'b0;
  assign serial_data_pin_o = 1'b0;
  assign serial_clock_pin_oe_o = r.scl_oe;
  assign serial_data_pin_oe_o = r.sda_oe;
  assign busy_o = r.busy;
  assign rx_nack_o = r.nack;
  assign arb_lost_o = r.arb;
  assign rx_data_o = r.rx;
  assign done_o = r.done;
  assign serial_iface_irq_source_o = r.irq;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence start_edge_s;
    $rose(serial_data_pin_oe_o) && !serial_clock_pin_oe_o;
  endsequence
  sequence stop_edge_s;
    $fell(serial_data_pin_oe_o) && !serial_clock_pin_oe_o && !$past(serial_clock_pin_oe_o) && $past(enable_i);
  endsequence

  pins_low_only_a: assert property (!serial_clock_pin_o && !serial_data_pin_o) // [R22]
    else $error("bus pin driven high");
  disable_release_a: assert property (!enable_i |=> !serial_clock_pin_oe_o && !serial_data_pin_oe_o) // [R4]
    else $error("pins not released on disable");
  load_quiet_a: assert property (r.state == twsm_pkg::S_IDLE && !r.owned && !cmd_go // [R7]
    |=> !serial_clock_pin_oe_o && !serial_data_pin_oe_o)
    else $error("bus activity without command");
  start_cond_a: assert property (start_edge_s // [R8]
    |-> r.state == twsm_pkg::S_START && $past(r.state) == twsm_pkg::S_START)
    else $error("data fell under high clock outside start");
  stop_cond_a: assert property (stop_edge_s // [R13]
    |-> r.state == twsm_pkg::S_STOP || $past(r.state) == twsm_pkg::S_STOP)
    else $error("data rose under high clock outside stop");
  write_no_start_a: assert property (cmd_go && !cmd_start_i // [R12]
    |=> r.state != twsm_pkg::S_START ##1 r.state != twsm_pkg::S_START)
    else $error("start generated for plain command");
  busy_flag_a: assert property (cmd_go |=> busy_o && !arb_lost_o && !rx_nack_o) // [R17]
    else $error("busy not raised on command");
  ack_record_a: assert property (adv && np == twsm_pkg::PH_SAMPLE && enable_i // [R18]
    && r.state == twsm_pkg::S_ACK && !r.c_rd |=> rx_nack_o == $past(r.lvl[1]))
    else $error("acknowledge not recorded");
  arb_loss_a: assert property (adv && np == twsm_pkg::PH_SAMPLE && enable_i // [R19] [R5]
    && r.state == twsm_pkg::S_BIT && !r.c_rd && r.sh[7] && !r.lvl[1]
    |=> arb_lost_o && !busy_o && !serial_clock_pin_oe_o && !serial_data_pin_oe_o)
    else $error("arbitration loss not handled");
  read_ack_a: assert property (r.state == twsm_pkg::S_ACK && r.c_rd && r.phase != 3'h0 // [R20]
    |-> serial_data_pin_oe_o == !r.c_nack)
    else $error("wrong acknowledge driven on read");
  cmd_clear_a: assert property ($fell(busy_o) && enable_i |-> done_o && r.state == twsm_pkg::S_IDLE) // [R21]
    else $error("busy cleared without completion");
  irq_gate_a: assert property (serial_iface_irq_source_o |-> done_o && r.cfg_irq) // [R16]
    else $error("interrupt without enabled event");
  presc_range_a: assert property (r.busy |-> r.pcnt <= r.cfg_presc) // [R1]
    else $error("prescaler count overran");
  filter_width_a: assert property ($changed(r.lvl[1]) && $past(r.cfg_filt) && $past(enable_i) // [R3]
    |-> $past(r.fcnt[1]) == twsm_pkg::FILT_LAST)
    else $error("short pulse passed filter");
endmodule // twsm_master
`default_nettype wire

// ---- inc/twsm_pkg.sv ----
// Overview of operation
// R1: clock is 16 MHz over five times prescaler-plus-one
// R2: dedicated clock pin and bidirectional data pin
// R3: optional filter drops pulses under 62.5 ns
// R4: software disable releases both bus pins
// R5: master takes part in bus arbitration
// R6: loser abandons transfer, retries when bus free (code goes idle with arb_lost_o set and never retries)
// R7: loading buffer only stores, nothing on bus
// R8: start plus write sends start, then address
// R9: 7-bit target: address plus direction bit
// R10: 10-bit first byte: upper bits OR 0x78
// R11: 10-bit low eight bits sent as plain write
// R12: write alone sends byte without start or stop
// R13: write plus stop sends byte then stop
// R14: controller waits for completion before next command
// R15: 10-bit first byte succeeds on any matching acknowledge
// R16: interrupt on bus events when enabled at configuration
// R17: readable transfer-in-progress flag
// R18: acknowledge or not-acknowledge recorded per byte
// R19: readable arbitration-lost status
// R20: read clocks byte in, sends chosen acknowledge, optional stop
// R21: command bits clear when transfer and stop done
// R22: lines only pulled low or released
package twsm_pkg;
  localparam int SYS_CLK_HZ = 200_000_000;
  localparam int REF_CLK_HZ = 16_000_000;
  localparam logic [7:0] REF_STEP = 8'(REF_CLK_HZ / 1_000_000);
  localparam logic [7:0] REF_MOD = 8'(SYS_CLK_HZ / 1_000_000);
  localparam logic [2:0] PH_RISE = 3'h2;
  localparam logic [2:0] PH_SAMPLE = 3'h3;
  localparam logic [2:0] PH_LAST = 3'h4;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int FILT_TIME_PS = 62500;
  localparam int CLK_PERIOD_PS = 1_000_000_000 / (SYS_CLK_HZ / 1000);
  localparam int FILT_CYC = (FILT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] FILT_LAST = 4'(FILT_CYC - 1);
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_START, S_BIT, S_ACK, S_STOP} twsm_state_t;
endpackage

// ---- design/twsm_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none
module twsm_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [W-1:0] wr_data_i,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [W-1:0] rd_data_o
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] cnt;
  } twsm_fifo_regs_t;
  twsm_fifo_regs_t f_reg, f_next;
  logic [W-1:0] mem [D];
  logic push, pop;

  assign wr_ready_o = f_reg.cnt != CW'(D);
  assign rd_valid_o = f_reg.cnt != '0;
  assign rd_data_o = mem[f_reg.rptr];
  assign push = wr_valid_i && wr_ready_o;
  assign pop = rd_ready_i && rd_valid_o;

  always_comb
  begin
    f_next = f_reg;
    if (push)
      f_next.wptr = (f_reg.wptr == AW'(D - 1)) ? '0 : f_reg.wptr + 1'b1;
    if (pop)
      f_next.rptr = (f_reg.rptr == AW'(D - 1)) ? '0 : f_reg.rptr + 1'b1;
    if (push && !pop)
      f_next.cnt = f_reg.cnt + 1'b1;
    else if (pop && !push)
      f_next.cnt = f_reg.cnt - 1'b1;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      f_reg <= '0;
    else
      f_reg <= f_next;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (push)
      mem[f_reg.wptr] <= wr_data_i;
  end
endmodule // twsm_fifo
`default_nettype wire

// ---- testbench/twsm_bus_slave.sv ----
`timescale 1ns/100ps
`default_nettype none
module twsm_bus_slave (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic nack_en_i,
  input wire logic stretch_i,
  input wire logic [7:0] rd_byte_i,
  output logic scl_oe_o = 1'h0,
  output logic sda_oe_o = 1'h0,
  output logic [7:0] got_o = 8'h00,
  output logic mack_o = 1'h0,
  output int starts_o = 0,
  output int stops_o = 0
);
  logic [7:0] sh = 8'h00, cur = 8'h00;
  logic rd = 1'h0, first = 1'h0;
  int cnt = 0;
  ////////////////////////////////////////
  // start or stop: data line moves while the clock line is high
  always @(sda_i)
    if (scl_i)
    begin
      if (sda_i)
        stops_o++;
      else
        starts_o++;
      first = !sda_i;
      cnt = 0;
      rd = 1'h0;
      sda_oe_o = 1'h0;
    end
  always @(posedge scl_i)
  begin
    if (cnt < 8)
      sh = {sh[6:0], sda_i};
    else
      mack_o = sda_i;
    cnt++;
  end
  // ack a written byte; in read mode send bits, then leave the line to the master
  always @(negedge scl_i)
  begin
    if (cnt == 8 && !rd)
    begin
      got_o = sh;
      sda_oe_o = !nack_en_i;
    end
    else if (cnt == 9)
    begin
      cnt = 0;
      cur = rd ? ~cur : rd_byte_i;
      // a not-acknowledge from the master ends the read and frees the data line
      rd = (rd & !mack_o) | (first & got_o[0]);
      first = 1'h0;
    end
    if (rd)
      sda_oe_o = (cnt < 8) ? !cur[7 - cnt] : 1'h0;
    else if (cnt == 0)
      sda_oe_o = 1'h0;
  end
  // slow slave: holds each low phase of the clock
  always @(negedge scl_i)
    if (stretch_i)
    begin
      scl_oe_o = 1'h1;
      #400;
      scl_oe_o = 1'h0;
    end
endmodule // twsm_bus_slave
`default_nettype wire

// ---- testbench/two_wire_serial_master_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module two_wire_serial_master_test;
  localparam logic [4:0] CMD_SW = 5'h14;
  localparam logic [4:0] CMD_SWP = 5'h1c;
  localparam logic [4:0] CMD_W = 5'h04;
  localparam logic [4:0] CMD_WP = 5'h0c;
  localparam logic [4:0] CMD_RD = 5'h02;
  localparam logic [4:0] CMD_RPN = 5'h0b;
  logic sys_clk_i = 1'h0, reset_i = 1'h1, enable_i = 1'h0, filter_en_i = 1'h0, irq_en_i = 1'h0;
  logic load_target_address_i = 1'h0, target_rd_i = 1'h0, load_tx_byte_i = 1'h0, issue_bus_command_i = 1'h0;
  logic cmd_start_i = 1'h0, cmd_stop_i = 1'h0, cmd_write_i = 1'h0, cmd_read_i = 1'h0, cmd_nack_i = 1'h0;
  logic [7:0] prescaler_i = 8'h00, tx_byte_i = 8'h00, rd_byte = 8'h00, rx_data_o, got;
  logic [6:0] target_addr_i = 7'h00;
  logic buf_ready_o, cmd_ready_o, busy_o, rx_nack_o, arb_lost_o, done_o, serial_iface_irq_source_o;
  logic serial_clock_pin_o, serial_clock_pin_oe_o, serial_data_pin_o, serial_data_pin_oe_o, s_scl_oe, s_sda_oe, mack;
  logic jam = 1'h0, nack_en = 1'h0, stretch = 1'h0;
  int miscompares = 0, comparisons = 0, starts, stops, dones = 0, irqs = 0;
  // pulled-up lines: any party pulling low wins
  wire logic serial_clock_pin_i = !(serial_clock_pin_oe_o | s_scl_oe);
  wire logic serial_data_pin_i = !(serial_data_pin_oe_o | s_sda_oe | jam);

  twsm_master i_twsm_master (
    .sys_clk_i, .reset_i, .enable_i, .prescaler_i, .filter_en_i, .irq_en_i, .load_target_address_i,
    .target_addr_i, .target_rd_i, .load_tx_byte_i, .tx_byte_i, .buf_ready_o, .issue_bus_command_i,
    .cmd_start_i, .cmd_stop_i, .cmd_write_i, .cmd_read_i, .cmd_nack_i, .cmd_ready_o, .busy_o, .rx_nack_o,
    .arb_lost_o, .rx_data_o, .done_o, .serial_iface_irq_source_o, .serial_clock_pin_i, .serial_clock_pin_o,
    .serial_clock_pin_oe_o, .serial_data_pin_i, .serial_data_pin_o, .serial_data_pin_oe_o
  );
  twsm_bus_slave i_twsm_bus_slave (
    .scl_i(serial_clock_pin_i), .sda_i(serial_data_pin_i), .nack_en_i(nack_en), .stretch_i(stretch),
    .rd_byte_i(rd_byte), .scl_oe_o(s_scl_oe), .sda_oe_o(s_sda_oe), .got_o(got), .mack_o(mack),
    .starts_o(starts), .stops_o(stops)
  );
  ////////////////////////////////////////
  task automatic note(input string n, input bit ok, input string e, input string s);
    comparisons++;
    if (!ok)
    begin
      miscompares++;
      $display("Error %s expected %s seen %s", n, e, s);
    end
  endtask
  task automatic chkb(input string n, input logic e, input logic s);
    note(n, s === e, $sformatf("%b", e), $sformatf("%b", s));
  endtask
  task automatic chkv(input string n, input logic [7:0] e, input logic [7:0] s);
    note(n, s === e, $sformatf("%h", e), $sformatf("%h", s));
  endtask
  task automatic chkn(input string n, input int e, input int s);
    note(n, s == e, $sformatf("%0d", e), $sformatf("%0d", s));
  endtask
  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic en(input logic [7:0] p, input logic f, input logic i);
    @(posedge sys_clk_i);
    enable_i <= 1'h0;
    @(posedge sys_clk_i);
    {prescaler_i, filter_en_i, irq_en_i, enable_i} <= {p, f, i, 1'h1};
    repeat (3) @(posedge sys_clk_i);
  endtask
  task automatic load(input logic a, input logic [7:0] v);
    @(posedge sys_clk_i);
    if (a)
      {load_target_address_i, target_addr_i, target_rd_i} <= {1'h1, v};
    else
      {load_tx_byte_i, tx_byte_i} <= {1'h1, v};
    @(posedge sys_clk_i);
    load_target_address_i <= 1'h0;
    load_tx_byte_i <= 1'h0;
    #1;
  endtask
  task automatic go(input logic [4:0] c);
    @(posedge sys_clk_i);
    {cmd_start_i, cmd_stop_i, cmd_write_i, cmd_read_i, cmd_nack_i, issue_bus_command_i} <= {c, 1'h1};
    @(posedge sys_clk_i);
    issue_bus_command_i <= 1'h0;
    #1 chkb("busy", 1'h1, busy_o);
  endtask
  task automatic cmd(input logic [4:0] c);
    int k = 0;
    go(c);
    while (done_o !== 1'h1 && k < 20000)
    begin
      @(posedge sys_clk_i);
      #1 k++;
    end
    chkb("done", 1'h1, done_o);
    chkb("cmd_ready", 1'h1, cmd_ready_o);
  endtask
  function automatic logic [7:0] ten_first(input logic [9:0] w);
    return {7'h78 | {5'h00, w[9:8]}, 1'h0};
  endfunction
  ////////////////////////////////////////
  always #2.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    if (done_o === 1'h1)
      dones++;
    if (serial_iface_irq_source_o === 1'h1)
      irqs++;
    chkb("scl_level", 1'h0, serial_clock_pin_o);
    chkb("sda_level", 1'h0, serial_data_pin_o);
  end
  initial
  begin
    repeat (60000) @(posedge sys_clk_i);
    miscompares++;
    end_sim();
  end
  initial
  begin
    logic [6:0] a;
    logic [7:0] d;
    logic [9:0] w;
    logic [7:0] q[$];
    int n0, n1, e;
    realtime t0;
    void'($urandom(32'h368c78c8));
    repeat (3) @(posedge sys_clk_i);
    reset_i <= 1'h0;
    en(8'h00, 1'h0, 1'h1);
    a = 7'($urandom());
    n0 = starts;
    load(1'h1, {a, 1'h0});
    repeat (40) @(posedge sys_clk_i);
    chkn("starts", n0, starts);
    chkb("sda_oe", 1'h0, serial_data_pin_oe_o);
    cmd(CMD_SW);
    chkn("starts", n0 + 1, starts);
    chkv("addr", {a, 1'h0}, got);
    chkb("rx_nack", 1'h0, rx_nack_o);
    // fill the buffer until it refuses, drain it against a stalling slave
    stretch = 1'h1;
    repeat (8)
    begin
      d = 8'($urandom());
      q.push_back(d);
      load(1'h0, d);
    end
    chkb("buf_ready", 1'h0, buf_ready_o);
    n0 = starts;
    n1 = stops;
    for (int i = 0; i < 8; i++)
    begin
      cmd(i == 7 ? CMD_WP : CMD_W);
      chkv("data", q[i], got);
    end
    stretch = 1'h0;
    chkb("buf_ready", 1'h1, buf_ready_o);
    chkn("starts", n0, starts);
    chkn("stops", n1 + 1, stops);
    chkb("scl_oe", 1'h0, serial_clock_pin_oe_o);
    nack_en = 1'h1;
    load(1'h1, {a, 1'h0});
    cmd(CMD_SWP);
    chkb("rx_nack", 1'h1, rx_nack_o);
    nack_en = 1'h0;
    w = 10'($urandom());
    load(1'h1, ten_first(w));
    cmd(CMD_SW);
    chkv("addr_hi", ten_first(w), got);
    chkb("rx_nack", 1'h0, rx_nack_o);
    n0 = starts;
    load(1'h0, w[7:0]);
    cmd(CMD_WP);
    chkv("addr_lo", w[7:0], got);
    chkn("starts", n0, starts);
    d = 8'($urandom());
    rd_byte = d;
    load(1'h1, {a, 1'h1});
    cmd(CMD_SW);
    cmd(CMD_RD);
    chkv("rx_data", d, rx_data_o);
    chkb("master_ack", 1'h0, mack);
    n1 = stops;
    cmd(CMD_RPN);
    chkv("rx_data", ~d, rx_data_o);
    chkb("master_ack", 1'h1, mack);
    chkn("stops", n1 + 1, stops);
    // a competing master holds the data line low under our first 1 bit
    load(1'h1, 8'hff);
    fork
      cmd(CMD_SW);
      @(negedge serial_clock_pin_i) jam = 1'h1;
    join
    chkb("arb_lost", 1'h1, arb_lost_o);
    chkb("sda_oe", 1'h0, serial_data_pin_oe_o);
    jam = 1'h0;
    load(1'h1, {a, 1'h0});
    cmd(CMD_SWP);
    chkb("arb_lost", 1'h0, arb_lost_o);
    chkv("addr", {a, 1'h0}, got);
    for (int p = 0; p < 3; p++)
    begin
      en(8'(p), 1'h0, 1'h1);
      load(1'h1, {a, 1'h0});
      go(CMD_SWP);
      @(negedge serial_clock_pin_i);
      @(posedge serial_clock_pin_i);
      t0 = $realtime;
      @(posedge serial_clock_pin_i);
      n0 = int'($realtime - t0);
      e = int'(312.5 * (p + 1));
      chkn("scl_period_ns", e, (n0 >= e - 6 && n0 <= e + 6) ? e : n0);
      @(posedge done_o);
    end
    chkn("irqs", dones, irqs);
    nack_en = 1'h1;
    load(1'h1, {a, 1'h0});
    go(CMD_SW);
    repeat (75) @(posedge sys_clk_i);
    enable_i <= 1'h0;
    @(posedge sys_clk_i);
    #1 chkb("scl_oe", 1'h0, serial_clock_pin_oe_o);
    chkb("sda_oe", 1'h0, serial_data_pin_oe_o);
    chkb("busy", 1'h0, busy_o);
    en(8'h00, 1'h0, 1'h0);
    n0 = irqs;
    load(1'h1, {a, 1'h0});
    cmd(CMD_SWP);
    chkn("irqs", n0, irqs);
    // a 45 ns low spike on a sent 1 bit must not cost arbitration
    en(8'h00, 1'h1, 1'h0);
    load(1'h1, 8'hfe);
    fork
      cmd(CMD_SWP);
      begin
        @(negedge serial_clock_pin_i);
        @(posedge serial_clock_pin_i);
        #40 jam = 1'h1;
        #45 jam = 1'h0;
      end
    join
    chkb("arb_lost", 1'h0, arb_lost_o);
    end_sim();
  end
endmodule // two_wire_serial_master_test
`default_nettype wire
